// *** inc/gpfd_pkg.sv ***
package gpfd_pkg;
	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 8;
	localparam int NUM_PINS = NUM_PORTS * PORT_W;
	localparam int NUM_ALT = 4;
	localparam int PORT_D_IDX = 3;

	// Register file placement
	localparam logic [11:0] REG_BASE = 12'hfd0;
	localparam logic [11:0] REG_SPAN = 12'h014;
	localparam logic [1:0] OFF_SELECTOR = 2'h0;
	localparam logic [1:0] OFF_WINDOW = 2'h1;

	// Subregister selector codes
	localparam logic [7:0] SEL_NONE = 8'h00;
	localparam logic [7:0] SEL_DIR = 8'h01;
	localparam logic [7:0] SEL_ALT_EN = 8'h02;
	localparam logic [7:0] SEL_OPEN_DRAIN = 8'h03;
	localparam logic [7:0] SEL_HIGH_DRIVE = 8'h04;
	localparam logic [7:0] SEL_ALT_SET_ONE = 8'h07;
	localparam logic [7:0] SEL_ALT_SET_TWO = 8'h08;

	// Reset values
	localparam logic [7:0] RST_SELECTOR = 8'h00;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_ALT_EN = 8'h00;
	localparam logic [7:0] RST_ALT_EN_PORT_D = 8'h01;
	localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
	localparam logic [7:0] RST_HIGH_DRIVE = 8'h00;
	localparam logic [7:0] RST_ALT_SET = 8'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;
endpackage

// *** rtl/gpfd_port_cfg.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpfd_port_cfg
	import gpfd_pkg::*;
#(
	parameter logic [7:0] ALT_EN_RST = 8'h00
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic selector_wr,
	input wire logic window_wr,
	input wire logic [7:0] wdata,
	output logic [7:0] port_subreg_selector,
	output logic [7:0] window_rdata,
	output logic [7:0] pin_direction_subreg,
	output logic [7:0] pin_alt_function_enable,
	output logic [7:0] pin_open_drain_control,
	output logic [7:0] pin_high_drive_enable,
	output logic [7:0] alt_function_set_one,
	output logic [7:0] alt_function_set_two
);
	logic [7:0] sel_q, sel_d;
	logic [7:0] dir_q, dir_d;
	logic [7:0] af_q, af_d;
	logic [7:0] oc_q, oc_d;
	logic [7:0] hde_q, hde_d;
	logic [7:0] afs1_q, afs1_d;
	logic [7:0] afs2_q, afs2_d;

	always_comb
	begin
		sel_d = sel_q;
		dir_d = dir_q;
		af_d = af_q;
		oc_d = oc_q;
		hde_d = hde_q;
		afs1_d = afs1_q;
		afs2_d = afs2_q;
		if (selector_wr)
		begin
			sel_d = wdata;
		end
		if (window_wr)
		begin
			// Code 00h and spare codes swallow the write, guarding against stray setup
			case (sel_q)
				SEL_DIR: dir_d = wdata;
				SEL_ALT_EN: af_d = wdata;
				SEL_OPEN_DRAIN: oc_d = wdata;
				SEL_HIGH_DRIVE: hde_d = wdata;
				SEL_ALT_SET_ONE: afs1_d = wdata;
				SEL_ALT_SET_TWO: afs2_d = wdata;
				default: sel_d = sel_d;
			endcase
		end
	end

	always_comb
	begin
		case (sel_q)
			SEL_DIR: window_rdata = dir_q;
			SEL_ALT_EN: window_rdata = af_q;
			SEL_OPEN_DRAIN: window_rdata = oc_q;
			SEL_HIGH_DRIVE: window_rdata = hde_q;
			SEL_ALT_SET_ONE: window_rdata = afs1_q;
			SEL_ALT_SET_TWO: window_rdata = afs2_q;
			default: window_rdata = RDATA_NONE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel_q <= RST_SELECTOR;
			dir_q <= RST_DIR;
			af_q <= ALT_EN_RST;
			oc_q <= RST_OPEN_DRAIN;
			hde_q <= RST_HIGH_DRIVE;
			afs1_q <= RST_ALT_SET;
			afs2_q <= RST_ALT_SET;
		end
		else
		begin
			sel_q <= sel_d;
			dir_q <= dir_d;
			af_q <= af_d;
			oc_q <= oc_d;
			hde_q <= hde_d;
			afs1_q <= afs1_d;
			afs2_q <= afs2_d;
		end
	end

	assign port_subreg_selector = sel_q;
	assign pin_direction_subreg = dir_q;
	assign pin_alt_function_enable = af_q;
	assign pin_open_drain_control = oc_q;
	assign pin_high_drive_enable = hde_q;
	assign alt_function_set_one = afs1_q;
	assign alt_function_set_two = afs2_q;
endmodule
`default_nettype wire

// *** rtl/gpfd_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpfd_top
	import gpfd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	input wire logic [NUM_PINS-1:0] gpio_out_data,
	input wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out_val,
	input wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out_en,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out_q,
	output logic [NUM_PINS-1:0] pin_oe_n_q,
	output logic [NUM_PINS-1:0] pin_high_drive_q,
	output logic [NUM_PINS-1:0] pin_in_q,
	output logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_route_q
);
	logic [11:0] addr_off;
	logic addr_hit;
	logic [2:0] port_idx;
	logic [NUM_PORTS-1:0] sel_wr;
	logic [NUM_PORTS-1:0] win_wr;
	logic [NUM_PORTS-1:0][7:0] sel_val;
	logic [NUM_PORTS-1:0][7:0] win_rdata;
	logic [NUM_PINS-1:0] dir_all;
	logic [NUM_PINS-1:0] af_all;
	logic [NUM_PINS-1:0] oc_all;
	logic [NUM_PINS-1:0] hde_all;
	logic [NUM_PINS-1:0] afs1_all;
	logic [NUM_PINS-1:0] afs2_all;
	logic [7:0] rdata_d;
	logic [NUM_PINS-1:0] pin_out_d;
	logic [NUM_PINS-1:0] pin_oe_n_d;
	logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_route_d;

	// Address decode: two byte registers per four-byte slot
	assign addr_off = reg_addr - REG_BASE;
	assign addr_hit = (reg_addr >= REG_BASE) && (addr_off < REG_SPAN);
	assign port_idx = addr_off[4:2];

	always_comb
	begin
		sel_wr = '0;
		win_wr = '0;
		rdata_d = RDATA_NONE;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (addr_hit && port_idx == p[2:0])
			begin
				sel_wr[p] = reg_wr && addr_off[1:0] == OFF_SELECTOR;
				win_wr[p] = reg_wr && addr_off[1:0] == OFF_WINDOW;
				if (addr_off[1:0] == OFF_SELECTOR)
				begin
					rdata_d = sel_val[p];
				end
				else if (addr_off[1:0] == OFF_WINDOW)
				begin
					rdata_d = win_rdata[p];
				end
			end
		end
		// Read data holds between reads so a slow master can sample it late
		if (!reg_rd)
		begin
			rdata_d = reg_rdata_q;
		end
	end

	for (genvar g = 0; g < NUM_PORTS; g++)
	begin : g_port
		gpfd_port_cfg #(
			.ALT_EN_RST((g == PORT_D_IDX) ? RST_ALT_EN_PORT_D : RST_ALT_EN)
		) gpfd_port_cfg_inst (
			.clk(clk),
			.rst(rst),
			.selector_wr(sel_wr[g]),
			.window_wr(win_wr[g]),
			.wdata(reg_wdata),
			.port_subreg_selector(sel_val[g]),
			.window_rdata(win_rdata[g]),
			.pin_direction_subreg(dir_all[g*PORT_W +: PORT_W]),
			.pin_alt_function_enable(af_all[g*PORT_W +: PORT_W]),
			.pin_open_drain_control(oc_all[g*PORT_W +: PORT_W]),
			.pin_high_drive_enable(hde_all[g*PORT_W +: PORT_W]),
			.alt_function_set_one(afs1_all[g*PORT_W +: PORT_W]),
			.alt_function_set_two(afs2_all[g*PORT_W +: PORT_W])
		);
	end

	// Pin steering; a pin enabled with no peripheral behind it follows idle peripheral inputs
	always_comb
	begin
		logic [1:0] fsel;
		logic val;
		logic en;
		fsel = 2'h0;
		val = 1'b0;
		en = 1'b0;
		pin_out_d = '0;
		pin_oe_n_d = '1;
		alt_route_d = '0;
		for (int i = 0; i < NUM_PINS; i++)
		begin
			fsel = {afs2_all[i], afs1_all[i]};
			if (af_all[i])
			begin
				val = alt_out_val[fsel][i];
				en = alt_out_en[fsel][i];
				alt_route_d[fsel][i] = 1'b1;
			end
			else
			begin
				val = gpio_out_data[i];
				en = !dir_all[i];
			end
			if (oc_all[i])
			begin
				pin_out_d[i] = 1'b0;
				pin_oe_n_d[i] = !(en && !val);
			end
			else
			begin
				pin_out_d[i] = val;
				pin_oe_n_d[i] = !en;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata_q <= RDATA_NONE;
			pin_out_q <= '0;
			pin_oe_n_q <= '1;
			pin_high_drive_q <= '0;
			pin_in_q <= '0;
			alt_route_q <= '0;
		end
		else
		begin
			reg_rdata_q <= rdata_d;
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
			pin_high_drive_q <= hde_all;
			pin_in_q <= pin_in;
			alt_route_q <= alt_route_d;
		end
	end
endmodule
`default_nettype wire

// *** tb/gpfd_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpfd_properties
	import gpfd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic [NUM_PINS-1:0] gpio_out_data,
	input wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out_val,
	input wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out_en,
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [NUM_PINS-1:0] pin_out_q,
	input wire logic [NUM_PINS-1:0] pin_oe_n_q,
	input wire logic [NUM_PINS-1:0] pin_high_drive_q,
	input wire logic [NUM_PINS-1:0] pin_in_q,
	input wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_route_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic [NUM_PINS-1:0] no_route = ~(alt_route_q[0] | alt_route_q[1] | alt_route_q[2] | alt_route_q[3]);
	a_in_sample: assert property (!$past(rst) |-> pin_in_q == $past(pin_in))
		else $error("pin sample lost");
	a_rd_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata_q))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 12'hfe1 |-> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	a_gpio_high_src: assert property ((no_route & pin_out_q & ~pin_oe_n_q & ~$past(gpio_out_data)) == '0)
		else $error("plain pin drives high without data");
	a_alt_tristate: assert property ((alt_route_q[0] & ~$past(alt_out_en[0]) & ~pin_oe_n_q) == '0)
		else $error("alternate pin drives without request");
	a_alt3_tristate: assert property ((alt_route_q[3] & ~$past(alt_out_en[3]) & ~pin_oe_n_q) == '0)
		else $error("function three pin drives without request");
	a_alt_high_src: assert property ((alt_route_q[1] & pin_out_q & ~pin_oe_n_q & ~$past(alt_out_val[1])) == '0)
		else $error("alternate pin drives wrong level");
	a_route_exclusive: assert property ((alt_route_q[0] & alt_route_q[3]) == '0)
		else $error("two functions on one pin");
	c_alt3: cover property (alt_route_q[3] != '0);
	c_unmapped: cover property (reg_rd && reg_addr > 12'hfe1);
	c_strong: cover property (pin_high_drive_q != '0);
endmodule
`default_nettype wire

// *** tb/gpfd_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpfd_pin_model
	import gpfd_pkg::*;
(
	input wire logic [NUM_PINS-1:0] pin_out_q,
	input wire logic [NUM_PINS-1:0] pin_oe_n_q,
	input wire logic [NUM_PINS-1:0] ext_level,
	output logic [NUM_PINS-1:0] pin_in
);
	// Released pins follow the outside level, never the last driven value
	assign pin_in = (pin_out_q & ~pin_oe_n_q) | (ext_level & pin_oe_n_q);
endmodule
`default_nettype wire

// *** tb/test_gpio_pin_function_drive_config.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_gpio_pin_function_drive_config
	import gpfd_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata_q;
	logic [NUM_PINS-1:0] gpio_out_data = '0, ext_level = '1, pin_in, pin_out_q, pin_oe_n_q, pin_high_drive_q, pin_in_q;
	logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out_val = '0, alt_out_en = '0, alt_route_q;
	logic [7:0] codes [6] = '{SEL_DIR, SEL_ALT_EN, SEL_OPEN_DRAIN, SEL_HIGH_DRIVE, SEL_ALT_SET_ONE, SEL_ALT_SET_TWO};
	int n_mismatch = 0, checked = 0, cyc = 0;
	gpfd_top gpfd_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .gpio_out_data(gpio_out_data),
		.alt_out_val(alt_out_val), .alt_out_en(alt_out_en), .pin_in(pin_in), .pin_out_q(pin_out_q),
		.pin_oe_n_q(pin_oe_n_q), .pin_high_drive_q(pin_high_drive_q), .pin_in_q(pin_in_q),
		.alt_route_q(alt_route_q));
	gpfd_pin_model gpfd_pin_model_inst (.pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
		.ext_level(ext_level), .pin_in(pin_in));
	initial forever #5 clk = ~clk;
	task results;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			results();
		end
	end
	task chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(40'(reg_rdata_q), 40'(e));
	endtask
	task sub(input int p, input logic [7:0] code, input logic [7:0] d);
		wr(REG_BASE + 12'(4 * p), code);
		wr(REG_BASE + 12'(4 * p + 1), d);
	endtask
	task rsub(input int p, input logic [7:0] code, input logic [7:0] e);
		wr(REG_BASE + 12'(4 * p), code);
		rd(REG_BASE + 12'(4 * p + 1), e);
	endtask
	// Pins answer one edge after the subregister write lands
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task s_regs;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			rsub(p, SEL_ALT_EN, (p == PORT_D_IDX) ? 8'h01 : 8'h00);
			rsub(p, SEL_OPEN_DRAIN, 8'h00);
			rsub(p, SEL_HIGH_DRIVE, 8'h00);
		end
		foreach (codes[i])
		begin
			sub(4, codes[i], 8'h90 + codes[i]);
			rsub(4, codes[i], 8'h90 + codes[i]);
		end
		sub(4, SEL_NONE, 8'hff);
		rsub(4, SEL_NONE, 8'h00);
		rd(12'hfe4, 8'h00);
	endtask
	task s_gpio;
		@(posedge clk);
		gpio_out_data <= 40'ha5;
		sub(0, SEL_DIR, 8'h00);
		settle();
		chk(pin_out_q & 40'hff, 40'ha5);
		chk(pin_oe_n_q & 40'hffff, 40'hff00);
		chk(pin_in_q & 40'hff, 40'ha5);
		sub(0, SEL_OPEN_DRAIN, 8'h0f);
		settle();
		chk(pin_out_q & 40'hff, 40'ha0);
		chk(pin_oe_n_q & 40'hff, 40'h05);
	endtask
	task s_drive;
		sub(1, SEL_HIGH_DRIVE, 8'h3c);
		settle();
		// Port E still holds 94h from the register sweep
		chk(pin_high_drive_q, 40'h94_0000_3c00);
	endtask
	task s_alt;
		@(posedge clk);
		// Every function drives every pin, so no enable lands on an empty pin
		alt_out_en <= '1;
		alt_out_val[0] <= '1;
		alt_out_val[2] <= '1;
		sub(2, SEL_ALT_SET_ONE, 8'haa);
		sub(2, SEL_ALT_SET_TWO, 8'hcc);
		sub(2, SEL_OPEN_DRAIN, 8'h0f);
		sub(2, SEL_HIGH_DRIVE, 8'hf0);
		sub(2, SEL_ALT_EN, 8'hff);
		settle();
		for (int f = 0; f < NUM_ALT; f++)
			chk(40'(alt_route_q[f][23:16]), 40'(8'h11 << f));
		chk(40'(pin_out_q[23:16]), 40'h50);
		chk(40'(pin_oe_n_q[23:16]), 40'h05);
		chk(40'(pin_high_drive_q[23:16]), 40'hf0);
		sub(2, SEL_ALT_EN, 8'h00);
		settle();
		chk(40'(pin_oe_n_q[23:16]), 40'hff);
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		s_regs();
		s_gpio();
		s_drive();
		s_alt();
		results();
	end
endmodule
bind gpfd_top gpfd_properties gpfd_properties_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .gpio_out_data(gpio_out_data),
	.alt_out_val(alt_out_val), .alt_out_en(alt_out_en), .pin_in(pin_in), .pin_out_q(pin_out_q),
	.pin_oe_n_q(pin_oe_n_q), .pin_high_drive_q(pin_high_drive_q), .pin_in_q(pin_in_q),
	.alt_route_q(alt_route_q));
`default_nettype wire
